/* usaa_pkg.sv */
// constants, field layout and carrier types for the serial port status and
// detection block; shared by the design and by whoever drives its ports
package usaa_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_STATUS   = 8'h1C;
	localparam logic [7:0] OFS_LOWPULSE = 8'h28;
	localparam logic [7:0] OFS_HIGHPULS = 8'h2C;
	localparam logic [7:0] OFS_EDGECNT  = 8'h30;
	localparam logic [7:0] OFS_PREIDLE  = 8'h50;
	localparam logic [7:0] OFS_POSTIDLE = 8'h54;
	localparam logic [7:0] OFS_GAPTOUT  = 8'h58;
	localparam logic [7:0] OFS_CMDCHAR  = 8'h5C;
	localparam logic [7:0] OFS_TXPTR    = 8'h64;
	localparam logic [7:0] OFS_RXPTR    = 8'h68;
	localparam logic [7:0] OFS_FSM      = 8'h6C;
	localparam logic [7:0] OFS_RISEMIN  = 8'h70;
	localparam logic [7:0] OFS_FALLMIN  = 8'h74;
	localparam logic [7:0] OFS_VERSION  = 8'h7C;
	localparam logic [7:0] OFS_IDENT    = 8'h80;

	// status register fields
	localparam int STAT_RXCNT_LSB = 0;
	localparam int STAT_DSR_BIT   = 13;
	localparam int STAT_CTS_BIT   = 14;
	localparam int STAT_RXD_BIT   = 15;
	localparam int STAT_TXCNT_LSB = 16;
	localparam int STAT_DTR_BIT   = 29;
	localparam int STAT_RTS_BIT   = 30;
	localparam int STAT_TXD_BIT   = 31;

	// pointer, state, command char and ident fields
	localparam int PTR_LO_LSB     = 0;
	localparam int PTR_HI_LSB     = 11;
	localparam int FSM_RX_LSB     = 0;
	localparam int FSM_TX_LSB     = 4;
	localparam int CHAR_VAL_LSB   = 0;
	localparam int CHAR_NUM_LSB   = 8;
	localparam int ID_CTRL_BIT    = 30;
	localparam int ID_UPD_BIT     = 31;

	// reset values
	localparam logic [15:0] PRE_IDLE_RST  = 16'h0003;
	localparam logic [15:0] POST_IDLE_RST = 16'h0003;
	localparam logic [15:0] GAP_TOUT_RST  = 16'h000B;
	localparam logic [7:0]  CHAR_VAL_RST  = 8'h2B;
	localparam logic [7:0]  CHAR_NUM_RST  = 8'h03;
	localparam logic [29:0] IDENT_RST     = 30'h0000_0500;
	localparam logic        IDCTRL_RST    = 1'b1;

	typedef struct packed {
		logic [15:0] pre_idle_bits;
		logic [15:0] post_idle_bits;
		logic [15:0] char_gap_limit;
		logic [7:0]  detect_char_value;
		logic [7:0]  detect_char_count;
	} usaa_at_cfg_t;

	typedef struct packed {
		logic set_ready_level;
		logic clear_to_send_level;
		logic rxd_level;
		logic terminal_ready_level;
		logic request_to_send_level;
		logic txd_level;
	} usaa_lines_t;

	typedef enum logic [1:0] {
		AT_IDLE,
		AT_COUNT,
		AT_POST
	} usaa_at_state_t;

endpackage

/* usaa_core.sv */
// status, baud measurement, command-character detection and register update
// assumes an apb-style register access and synchronous line levels from the port
`timescale 1ns/100ps

// Summary of operation
// - status register shows receive FIFO byte count, read only
// - status register shows transmit FIFO byte count, read only
// - status shows data-set-ready, clear-to-send and receive-data input levels
// - status shows terminal-ready, request-to-send and transmit-data output levels
// - transmit FIFO software write and engine read locations are readable
// - receive FIFO read and write locations readable, based at port base offset
// - receiver and transmitter state machine states are readable
// - shortest low pulse on receive line kept in clock cycles
// - longest high pulse on receive line kept in clock cycles
// - receive line level changes are counted and readable
// - smallest period between consecutive rising edges is kept
// - smallest period between consecutive falling edges is kept
// - programmable idle bit times required before first command character
// - programmable idle bit times required after last command character
// - programmable gap limit between successive command characters
// - command character value and consecutive count are programmable
// - update request copies configuration to core side, then self-clears
// - version register and port identifier field are read-write
// - baud measurement runs only while its enable is set
module usaa_core #(
	parameter int          CNT_W       = 12,
	parameter int          FIFO_AW     = 7,
	parameter logic [9:0]  RX_PTR_BASE = 10'h100,
	parameter logic [31:0] VERSION_RST = 32'h0000_0001  // arbitrary value
) (
	input  wire logic                  clock_i,
	input  wire logic                  nrst_i,
	input  wire logic                  ce_i,
	input  wire logic                  psel_i,
	input  wire logic                  penable_i,
	input  wire logic                  pwrite_i,
	input  wire logic [7:0]            paddr_i,
	input  wire logic [31:0]           pwdata_i,
	output logic      [31:0]           prdata_o,
	output logic                       pready_o,
	output logic                       pslverr_o,
	input  wire logic [9:0]            rx_fill_count_i,
	input  wire logic [9:0]            tx_fill_count_i,
	input  wire usaa_pkg::usaa_lines_t lines_i,
	input  wire logic [9:0]            tx_sw_write_ptr_i,
	input  wire logic [9:0]            tx_engine_read_ptr_i,
	input  wire logic [FIFO_AW-1:0]    rx_sw_read_idx_i,
	input  wire logic [FIFO_AW-1:0]    rx_engine_write_idx_i,
	input  wire logic [3:0]            receiver_state_i,
	input  wire logic [3:0]            transmitter_state_i,
	input  wire logic                  baud_detect_enable_i,
	input  wire logic                  bit_tick_i,
	input  wire logic                  rx_byte_valid_i,
	input  wire logic [7:0]            rx_byte_i,
	output usaa_pkg::usaa_at_cfg_t     core_cfg_o,
	output logic                       cfg_update_done_o,
	output logic                       at_cmd_detect_o
);

	localparam logic [CNT_W-1:0] CNT_MAX = '1;

	usaa_pkg::usaa_at_cfg_t   cfg_r;
	usaa_pkg::usaa_at_cfg_t   core_cfg_r;
	usaa_pkg::usaa_at_state_t at_state_r;
	logic [31:0]      version_r;
	logic [29:0]      ident_r;
	logic             idctrl_r;
	logic             upd_r;
	logic             done_r;
	logic [31:0]      rdata;
	logic [31:0]      prdata_r;
	logic             wr;
	logic             rd_setup;
	logic             set_upd;
	logic             rx_prev_r;
	logic             seen_edge_r;
	logic             seen_rise_r;
	logic             seen_fall_r;
	logic [CNT_W-1:0] run_r;
	logic [CNT_W-1:0] since_rise_r;
	logic [CNT_W-1:0] since_fall_r;
	logic [CNT_W-1:0] low_min_r;
	logic [CNT_W-1:0] high_len_r;
	logic [CNT_W-1:0] rise_min_r;
	logic [CNT_W-1:0] fall_min_r;
	logic [9:0]       edge_cnt_r;
	logic             rx_edge;
	logic             rx_rise;
	logic             rx_fall;
	logic [15:0]      idle_bits_r;
	logic [7:0]       at_cnt_r;
	logic             detect_r;
	logic [9:0]       rx_rd_ptr;
	logic [9:0]       rx_wr_ptr;

	function automatic logic is_mapped(input logic [7:0] a);
		case (a)
			usaa_pkg::OFS_STATUS, usaa_pkg::OFS_LOWPULSE, usaa_pkg::OFS_HIGHPULS,
			usaa_pkg::OFS_EDGECNT, usaa_pkg::OFS_PREIDLE, usaa_pkg::OFS_POSTIDLE,
			usaa_pkg::OFS_GAPTOUT, usaa_pkg::OFS_CMDCHAR, usaa_pkg::OFS_TXPTR,
			usaa_pkg::OFS_RXPTR, usaa_pkg::OFS_FSM, usaa_pkg::OFS_RISEMIN,
			usaa_pkg::OFS_FALLMIN, usaa_pkg::OFS_VERSION, usaa_pkg::OFS_IDENT:
				is_mapped = 1'b1;
			default:
				is_mapped = 1'b0;
		endcase
	endfunction

	function automatic logic [CNT_W-1:0] min_of(input logic [CNT_W-1:0] a,
		input logic [CNT_W-1:0] b);
		min_of = (a < b) ? a : b;
	endfunction

	function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] a);
		sat_inc = (a == CNT_MAX) ? a : a + 1'b1;
	endfunction

	// bus access: one wait-free access phase, frozen with the clock enable
	assign pready_o  = ce_i;
	assign pslverr_o = psel_i & penable_i & ~is_mapped(paddr_i);
	assign wr        = psel_i & penable_i & pwrite_i & ce_i;
	assign rd_setup  = psel_i & ~penable_i & ~pwrite_i & ce_i;
	assign set_upd   = wr & (paddr_i == usaa_pkg::OFS_IDENT) & pwdata_i[usaa_pkg::ID_UPD_BIT];
	assign prdata_o  = prdata_r;

	assign rx_rd_ptr = RX_PTR_BASE + 10'(rx_sw_read_idx_i);
	assign rx_wr_ptr = RX_PTR_BASE + 10'(rx_engine_write_idx_i);

	always_comb
	begin
		rdata = 32'h0000_0000;
		case (paddr_i)
			usaa_pkg::OFS_STATUS:
			begin
				rdata[usaa_pkg::STAT_RXCNT_LSB +: 10] = rx_fill_count_i;
				rdata[usaa_pkg::STAT_TXCNT_LSB +: 10] = tx_fill_count_i;
				rdata[usaa_pkg::STAT_DSR_BIT] = lines_i.set_ready_level;
				rdata[usaa_pkg::STAT_CTS_BIT] = lines_i.clear_to_send_level;
				rdata[usaa_pkg::STAT_RXD_BIT] = lines_i.rxd_level;
				rdata[usaa_pkg::STAT_DTR_BIT] = lines_i.terminal_ready_level;
				rdata[usaa_pkg::STAT_RTS_BIT] = lines_i.request_to_send_level;
				rdata[usaa_pkg::STAT_TXD_BIT] = lines_i.txd_level;
			end
			usaa_pkg::OFS_LOWPULSE: rdata[CNT_W-1:0] = low_min_r;
			usaa_pkg::OFS_HIGHPULS: rdata[CNT_W-1:0] = high_len_r;
			usaa_pkg::OFS_EDGECNT:  rdata[9:0] = edge_cnt_r;
			usaa_pkg::OFS_PREIDLE:  rdata[15:0] = cfg_r.pre_idle_bits;
			usaa_pkg::OFS_POSTIDLE: rdata[15:0] = cfg_r.post_idle_bits;
			usaa_pkg::OFS_GAPTOUT:  rdata[15:0] = cfg_r.char_gap_limit;
			usaa_pkg::OFS_CMDCHAR:
			begin
				rdata[usaa_pkg::CHAR_VAL_LSB +: 8] = cfg_r.detect_char_value;
				rdata[usaa_pkg::CHAR_NUM_LSB +: 8] = cfg_r.detect_char_count;
			end
			usaa_pkg::OFS_TXPTR:
			begin
				rdata[usaa_pkg::PTR_LO_LSB +: 10] = tx_sw_write_ptr_i;
				rdata[usaa_pkg::PTR_HI_LSB +: 10] = tx_engine_read_ptr_i;
			end
			usaa_pkg::OFS_RXPTR:
			begin
				rdata[usaa_pkg::PTR_LO_LSB +: 10] = rx_rd_ptr;
				rdata[usaa_pkg::PTR_HI_LSB +: 10] = rx_wr_ptr;
			end
			usaa_pkg::OFS_FSM:
			begin
				rdata[usaa_pkg::FSM_RX_LSB +: 4] = receiver_state_i;
				rdata[usaa_pkg::FSM_TX_LSB +: 4] = transmitter_state_i;
			end
			usaa_pkg::OFS_RISEMIN:  rdata[CNT_W-1:0] = rise_min_r;
			usaa_pkg::OFS_FALLMIN:  rdata[CNT_W-1:0] = fall_min_r;
			usaa_pkg::OFS_VERSION:  rdata = version_r;
			usaa_pkg::OFS_IDENT:
				rdata = {upd_r, idctrl_r, ident_r};
			default: rdata = 32'h0000_0000;
		endcase
	end

	// read data captured in the setup phase, held through the access phase
	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
			prdata_r <= 32'h0000_0000;
		else if (rd_setup)
			prdata_r <= rdata;
	end

	// writable configuration
	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			cfg_r.pre_idle_bits     <= usaa_pkg::PRE_IDLE_RST;
			cfg_r.post_idle_bits    <= usaa_pkg::POST_IDLE_RST;
			cfg_r.char_gap_limit    <= usaa_pkg::GAP_TOUT_RST;
			cfg_r.detect_char_value <= usaa_pkg::CHAR_VAL_RST;
			cfg_r.detect_char_count <= usaa_pkg::CHAR_NUM_RST;
			version_r               <= VERSION_RST;
			ident_r                 <= usaa_pkg::IDENT_RST;
			idctrl_r                <= usaa_pkg::IDCTRL_RST;
		end
		else if (wr)
		begin
			case (paddr_i)
				usaa_pkg::OFS_PREIDLE:  cfg_r.pre_idle_bits <= pwdata_i[15:0];
				usaa_pkg::OFS_POSTIDLE: cfg_r.post_idle_bits <= pwdata_i[15:0];
				usaa_pkg::OFS_GAPTOUT:  cfg_r.char_gap_limit <= pwdata_i[15:0];
				usaa_pkg::OFS_CMDCHAR:
				begin
					cfg_r.detect_char_value <= pwdata_i[usaa_pkg::CHAR_VAL_LSB +: 8];
					cfg_r.detect_char_count <= pwdata_i[usaa_pkg::CHAR_NUM_LSB +: 8];
				end
				usaa_pkg::OFS_VERSION: version_r <= pwdata_i;
				usaa_pkg::OFS_IDENT:
				begin
					ident_r  <= pwdata_i[29:0];
					idctrl_r <= pwdata_i[usaa_pkg::ID_CTRL_BIT];
				end
				default: ;
			endcase
		end
	end

	// update request: a new request beats the hardware clear
	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			upd_r      <= 1'b0;
			done_r     <= 1'b0;
			core_cfg_r <= '{usaa_pkg::PRE_IDLE_RST, usaa_pkg::POST_IDLE_RST,
				usaa_pkg::GAP_TOUT_RST, usaa_pkg::CHAR_VAL_RST, usaa_pkg::CHAR_NUM_RST};
		end
		else if (ce_i)
		begin
			done_r <= upd_r;
			if (upd_r)
				core_cfg_r <= cfg_r;
			if (set_upd)
				upd_r <= 1'b1;
			else if (upd_r)
				upd_r <= 1'b0;
		end
	end

	assign core_cfg_o        = core_cfg_r;
	assign cfg_update_done_o = done_r;

	// baud measurement on the receive line
	assign rx_edge = lines_i.rxd_level ^ rx_prev_r;
	assign rx_rise = rx_edge & lines_i.rxd_level;
	assign rx_fall = rx_edge & ~lines_i.rxd_level;

	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			rx_prev_r    <= 1'b1;
			seen_edge_r  <= 1'b0;
			seen_rise_r  <= 1'b0;
			seen_fall_r  <= 1'b0;
			run_r        <= '0;
			since_rise_r <= '0;
			since_fall_r <= '0;
			low_min_r    <= CNT_MAX;
			high_len_r   <= '0;
			rise_min_r   <= CNT_MAX;
			fall_min_r   <= CNT_MAX;
			edge_cnt_r   <= 10'h000;
		end
		else if (ce_i)
		begin
			rx_prev_r <= lines_i.rxd_level;
			if (!baud_detect_enable_i)
			begin
				seen_edge_r  <= 1'b0;
				seen_rise_r  <= 1'b0;
				seen_fall_r  <= 1'b0;
				run_r        <= '0;
				since_rise_r <= '0;
				since_fall_r <= '0;
				low_min_r    <= CNT_MAX;
				high_len_r   <= '0;
				rise_min_r   <= CNT_MAX;
				fall_min_r   <= CNT_MAX;
				edge_cnt_r   <= 10'h000;
			end
			else
			begin
				run_r        <= rx_edge ? CNT_W'(1) : sat_inc(run_r);
				since_rise_r <= rx_rise ? CNT_W'(1) : sat_inc(since_rise_r);
				since_fall_r <= rx_fall ? CNT_W'(1) : sat_inc(since_fall_r);
				if (rx_edge)
				begin
					seen_edge_r <= 1'b1;
					if (edge_cnt_r != 10'h3FF)
						edge_cnt_r <= edge_cnt_r + 10'h001;
				end
				if (rx_rise && seen_edge_r)
					low_min_r <= min_of(low_min_r, run_r);
				if (rx_fall && seen_edge_r && run_r > high_len_r)
					high_len_r <= run_r;
				if (rx_rise)
				begin
					seen_rise_r <= 1'b1;
					if (seen_rise_r)
						rise_min_r <= min_of(rise_min_r, since_rise_r);
				end
				if (rx_fall)
				begin
					seen_fall_r <= 1'b1;
					if (seen_fall_r)
						fall_min_r <= min_of(fall_min_r, since_fall_r);
				end
			end
		end
	end

	// idle time in bit times since the last received byte
	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
			idle_bits_r <= 16'hFFFF;
		else if (ce_i)
		begin
			if (rx_byte_valid_i)
				idle_bits_r <= 16'h0000;
			else if (bit_tick_i && idle_bits_r != 16'hFFFF)
				idle_bits_r <= idle_bits_r + 16'h0001;
		end
	end

	// command-character sequence detection using the core-side copy
	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			at_state_r <= usaa_pkg::AT_IDLE;
			at_cnt_r   <= 8'h00;
			detect_r   <= 1'b0;
		end
		else if (ce_i)
		begin
			detect_r <= 1'b0;
			case (at_state_r)
				usaa_pkg::AT_IDLE:
				begin
					if (rx_byte_valid_i && rx_byte_i == core_cfg_r.detect_char_value
						&& idle_bits_r >= core_cfg_r.pre_idle_bits)
					begin
						at_cnt_r <= 8'h01;
						if (core_cfg_r.detect_char_count <= 8'h01)
							at_state_r <= usaa_pkg::AT_POST;
						else
							at_state_r <= usaa_pkg::AT_COUNT;
					end
				end
				usaa_pkg::AT_COUNT:
				begin
					if (idle_bits_r > core_cfg_r.char_gap_limit)
						at_state_r <= usaa_pkg::AT_IDLE;
					else if (rx_byte_valid_i)
					begin
						if (rx_byte_i != core_cfg_r.detect_char_value)
							at_state_r <= usaa_pkg::AT_IDLE;
						else
						begin
							at_cnt_r <= at_cnt_r + 8'h01;
							if (at_cnt_r + 8'h01 >= core_cfg_r.detect_char_count)
								at_state_r <= usaa_pkg::AT_POST;
						end
					end
				end
				usaa_pkg::AT_POST:
				begin
					if (rx_byte_valid_i)
						at_state_r <= usaa_pkg::AT_IDLE;
					else if (idle_bits_r >= core_cfg_r.post_idle_bits)
					begin
						detect_r   <= 1'b1;
						at_state_r <= usaa_pkg::AT_IDLE;
					end
				end
				default: at_state_r <= usaa_pkg::AT_IDLE;
			endcase
		end
	end

	assign at_cmd_detect_o = detect_r;

	sequence seq_post_reached;
		at_state_r == usaa_pkg::AT_POST && ce_i && !rx_byte_valid_i;
	endsequence

	chk_update_clears: assert property (@(posedge clock_i) disable iff (!nrst_i)
		(upd_r && ce_i && !set_upd) |=> !upd_r)
		else $error("update request not cleared");
	chk_update_copies: assert property (@(posedge clock_i) disable iff (!nrst_i)
		(upd_r && ce_i) |=> (core_cfg_o == $past(cfg_r) && cfg_update_done_o))
		else $error("configuration not copied on update");
	chk_status_rxcnt: assert property (@(posedge clock_i) disable iff (!nrst_i)
		(rd_setup && paddr_i == usaa_pkg::OFS_STATUS) |=> prdata_o[9:0] == $past(rx_fill_count_i))
		else $error("receive fill count misread");
	chk_status_txcnt: assert property (@(posedge clock_i) disable iff (!nrst_i)
		(rd_setup && paddr_i == usaa_pkg::OFS_STATUS)
		|=> prdata_o[usaa_pkg::STAT_TXCNT_LSB +: 10] == $past(tx_fill_count_i))
		else $error("transmit fill count misread");
	chk_edge_counts: assert property (@(posedge clock_i) disable iff (!nrst_i)
		(ce_i && baud_detect_enable_i && rx_edge && edge_cnt_r != 10'h3FF)
		|=> edge_cnt_r == $past(edge_cnt_r) + 10'h001)
		else $error("edge not counted");
	chk_disable_clears: assert property (@(posedge clock_i) disable iff (!nrst_i)
		(ce_i && !baud_detect_enable_i) |=> (edge_cnt_r == 10'h000 && low_min_r == CNT_MAX))
		else $error("measurement ran while disabled");
	chk_low_min_falls: assert property (@(posedge clock_i) disable iff (!nrst_i)
		(ce_i && baud_detect_enable_i) |=> low_min_r <= $past(low_min_r))
		else $error("low pulse minimum grew");
	chk_rise_min_falls: assert property (@(posedge clock_i) disable iff (!nrst_i)
		(ce_i && baud_detect_enable_i && rx_rise && seen_rise_r)
		|=> rise_min_r <= $past(since_rise_r))
		else $error("rise period minimum not kept");
	chk_fall_min_falls: assert property (@(posedge clock_i) disable iff (!nrst_i)
		(ce_i && baud_detect_enable_i && rx_fall && seen_fall_r)
		|=> fall_min_r <= $past(since_fall_r))
		else $error("fall period minimum not kept");
	chk_detect_after_post: assert property (@(posedge clock_i) disable iff (!nrst_i)
		(seq_post_reached and (idle_bits_r >= core_cfg_r.post_idle_bits))
		|=> (at_cmd_detect_o && at_state_r == usaa_pkg::AT_IDLE))
		else $error("detection event missing");

endmodule

/* usaa_line_model.sv */
// serial device model driving the receive line of the port
// assumes the bench calls hold() and that levels change on the falling edge
`timescale 1ns/100ps
module usaa_line_model (
	input  wire logic clock_i,
	output logic      rxd_o
);
	// line idles high between pulses
	initial rxd_o = 1'b1;
	// level stands for n whole clock cycles
	task automatic hold(input logic lvl, input int n);
		@(negedge clock_i);
		rxd_o = lvl;
		repeat (n - 1) @(negedge clock_i);
	endtask
endmodule

/* test_uart_status_autobaud_atcmd.sv */
// self-checking bench for the status, measurement and command detection core
// assumes usaa_pkg and usaa_core are compiled first; the line model drives rxd
`timescale 1ns/100ps
`define CHK(nm, ex, gt) \
	begin \
		tests_run++; \
		if ((ex) !== (gt)) \
		begin \
			failures++; \
			$display("[FAIL] %s exp %h got %h", nm, ex, gt); \
		end \
	end
module test_uart_status_autobaud_atcmd;
	logic                   clock_i;
	logic                   nrst_i;
	logic                   ce;
	logic                   psel;
	logic                   pen;
	logic                   pwr;
	logic [7:0]             pa;
	logic [31:0]            pwd;
	logic [31:0]            prd;
	logic                   prdy;
	logic                   perr;
	logic [9:0]             rxc;
	logic [9:0]             txc;
	logic [5:0]             lvl;
	logic                   rxd;
	logic [9:0]             twp;
	logic [9:0]             trp;
	logic [6:0]             rrp;
	logic [6:0]             rwp;
	logic [3:0]             rst;
	logic [3:0]             tst;
	logic                   bd_en;
	logic                   tick;
	logic                   bval;
	logic [7:0]             bdat;
	usaa_pkg::usaa_at_cfg_t cfg;
	logic                   upd_done;
	logic                   det;
	usaa_pkg::usaa_lines_t  lines;
	int                     failures = 0;
	int                     tests_run = 0;
	int                     cycles = 0;
	int                     det_n = 0;
	int                     done_n = 0;
	logic [31:0]            rd;
	logic                   err;
	logic [31:0]            w;
	logic [7:0]  ra [11] = '{8'h50, 8'h54, 8'h58, 8'h5C, 8'h7C, 8'h80,
		8'h28, 8'h2C, 8'h30, 8'h70, 8'h74};
	logic [31:0] rv [11] = '{32'h3, 32'h3, 32'hB, 32'h32B, 32'h1, 32'h4000_0500,
		32'hFFF, 32'h0, 32'h0, 32'hFFF, 32'hFFF};
	logic [31:0] mk [6] = '{32'hFFFF, 32'hFFFF, 32'hFFFF, 32'hFFFF,
		32'hFFFF_FFFF, 32'h7FFF_FFFF};

	assign lines = {lvl[5:4], rxd, lvl[2:0]};

	usaa_core #(
		.RX_PTR_BASE(10'h180)
	) u_dut (
		.clock_i              (clock_i),
		.nrst_i               (nrst_i),
		.ce_i                 (ce),
		.psel_i               (psel),
		.penable_i            (pen),
		.pwrite_i             (pwr),
		.paddr_i              (pa),
		.pwdata_i             (pwd),
		.prdata_o             (prd),
		.pready_o             (prdy),
		.pslverr_o            (perr),
		.rx_fill_count_i      (rxc),
		.tx_fill_count_i      (txc),
		.lines_i              (lines),
		.tx_sw_write_ptr_i    (twp),
		.tx_engine_read_ptr_i (trp),
		.rx_sw_read_idx_i     (rrp),
		.rx_engine_write_idx_i(rwp),
		.receiver_state_i     (rst),
		.transmitter_state_i  (tst),
		.baud_detect_enable_i (bd_en),
		.bit_tick_i           (tick),
		.rx_byte_valid_i      (bval),
		.rx_byte_i            (bdat),
		.core_cfg_o           (cfg),
		.cfg_update_done_o    (upd_done),
		.at_cmd_detect_o      (det)
	);

	usaa_line_model u_line (
		.clock_i(clock_i),
		.rxd_o  (rxd)
	);

	initial
	begin
		clock_i = 1'b0;
		forever #20 clock_i = ~clock_i;
	end

	always @(posedge clock_i)
	begin
		cycles++;
		if (det === 1'b1)
			det_n++;
		if (upd_done === 1'b1)
			done_n++;
		if (cycles == 20000)
		begin
			failures++;
			tally_and_finish();
		end
	end

	function automatic logic [31:0] exp_stat();
		return {lvl[0], lvl[1], lvl[2], 3'b0, txc, rxd, lvl[4], lvl[5], 3'b0, rxc};
	endfunction

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(negedge clock_i);
		psel = 1'b1;
		pwr = wr;
		pa = a;
		pwd = d;
		@(negedge clock_i);
		pen = 1'b1;
		@(posedge clock_i);
		rd = prd;
		err = perr;
		@(negedge clock_i);
		psel = 1'b0;
		pen = 1'b0;
	endtask

	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] ex);
		apb(1'b0, a, 32'h0);
		`CHK(nm, ex, rd)
	endtask

	task automatic ticks(input int n);
		repeat (n)
		begin
			@(negedge clock_i);
			tick = 1'b1;
			@(negedge clock_i);
			tick = 1'b0;
			repeat (2) @(negedge clock_i);
		end
	endtask

	task automatic cmd(input int gap, input int nch, input logic [7:0] ch,
		input logic ab, input int ex);
		det_n = 0;
		ticks(3);
		for (int i = 0; i < nch; i++)
		begin
			@(negedge clock_i);
			bval = 1'b1;
			bdat = (ab && i == nch - 1) ? 8'h55 : ch;
			@(negedge clock_i);
			bval = 1'b0;
			if (i < nch - 1)
				ticks(gap);
		end
		ticks(4);
		`CHK("detect", ex, det_n)
		$display("test cmd gap %0d done", gap);
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial
	begin
		{nrst_i, psel, pen, pwr, pa, pwd, bd_en, tick, bval, bdat} = '0;
		{rxc, txc, lvl, twp, trp, rrp, rwp, rst, tst} = '0;
		ce = 1'b1;
		void'($urandom(32'h7814));
		repeat (4) @(negedge clock_i);
		nrst_i = 1'b1;
		for (int i = 0; i < 11; i++)
			rchk("reset", ra[i], rv[i]);
		$display("test reset done");
		repeat (8)
		begin
			{rxc, txc, lvl, twp, trp, rrp, rwp, rst, tst} = 68'({$urandom, $urandom, $urandom});
			rchk("status", usaa_pkg::OFS_STATUS, exp_stat());
			rchk("txptr", usaa_pkg::OFS_TXPTR, {11'b0, trp, 1'b0, twp});
			rchk("rxptr", usaa_pkg::OFS_RXPTR,
				{11'b0, 10'h180 + {3'b0, rwp}, 1'b0, 10'h180 + {3'b0, rrp}});
			rchk("fsm", usaa_pkg::OFS_FSM, {24'b0, tst, rst});
		end
		$display("test status done");
		for (int i = 0; i < 6; i++)
		begin
			w = $urandom & mk[i];
			apb(1'b1, ra[i], w);
			rchk("rw", ra[i], w);
		end
		apb(1'b1, usaa_pkg::OFS_STATUS, 32'hFFFF_FFFF);
		rchk("ro", usaa_pkg::OFS_STATUS, exp_stat());
		`CHK("slverr ok", 1'b0, err)
		rchk("unmapped", 8'h04, 32'h0);
		`CHK("slverr", 1'b1, err)
		$display("test rw done");
		apb(1'b1, usaa_pkg::OFS_PREIDLE, 32'h2);
		apb(1'b1, usaa_pkg::OFS_POSTIDLE, 32'h4);
		apb(1'b1, usaa_pkg::OFS_GAPTOUT, 32'h5);
		apb(1'b1, usaa_pkg::OFS_CMDCHAR, 32'h241);
		`CHK("cfg hold", {16'h3, 16'h3, 16'hB, 8'h2B, 8'h3}, cfg)
		apb(1'b1, usaa_pkg::OFS_IDENT, 32'h0000_0500);
		done_n = 0;
		apb(1'b1, usaa_pkg::OFS_IDENT, 32'h8000_0500);
		repeat (3) @(negedge clock_i);
		`CHK("cfg copy", {16'h2, 16'h4, 16'h5, 8'h41, 8'h2}, cfg)
		`CHK("done", 1, done_n)
		rchk("upd clear", usaa_pkg::OFS_IDENT, 32'h0000_0500);
		$display("test update done");
		cmd(5, 2, 8'h41, 1'b0, 1);
		cmd(6, 2, 8'h41, 1'b0, 0);
		cmd(2, 2, 8'h2B, 1'b0, 0);
		cmd(2, 3, 8'h41, 1'b1, 0);
		u_line.hold(1'b0, 3);
		bd_en = 1'b1;
		u_line.hold(1'b0, 5);
		u_line.hold(1'b1, 20);
		u_line.hold(1'b0, 10);
		u_line.hold(1'b1, 7);
		u_line.hold(1'b0, 6);
		u_line.hold(1'b1, 40);
		rchk("low min", usaa_pkg::OFS_LOWPULSE, 32'd6);
		rchk("high len", usaa_pkg::OFS_HIGHPULS, 32'd20);
		rchk("edges", usaa_pkg::OFS_EDGECNT, 32'd5);
		rchk("rise min", usaa_pkg::OFS_RISEMIN, 32'd13);
		rchk("fall min", usaa_pkg::OFS_FALLMIN, 32'd17);
		ce = 1'b0;
		u_line.hold(1'b0, 3);
		`CHK("ready low", 1'b0, prdy)
		u_line.hold(1'b1, 3);
		ce = 1'b1;
		`CHK("ready high", 1'b1, prdy)
		rchk("frozen edges", usaa_pkg::OFS_EDGECNT, 32'd5);
		bd_en = 1'b0;
		u_line.hold(1'b0, 3);
		u_line.hold(1'b1, 3);
		rchk("off low", usaa_pkg::OFS_LOWPULSE, 32'hFFF);
		rchk("off edges", usaa_pkg::OFS_EDGECNT, 32'd0);
		u_line.hold(1'b0, 1);
		rchk("rxd low", usaa_pkg::OFS_STATUS, exp_stat());
		$display("test baud done");
		tally_and_finish();
	end
endmodule
